/* rtl/aif_pkg.sv */
// Package for the converter interrupt flag block: offsets, layouts, resets.
// Assumes a 32-bit APB register bus with byte addresses.
package aif_pkg;

  // Number of interrupt lines served.
  localparam int AIF_LINES = 4;

  // Register byte offsets.
  localparam logic [7:0] OFS_FLAG = 8'h00;      // Flag status, read only.
  localparam logic [7:0] OFS_CLEAR = 8'h04;     // Flag clear, write one.
  localparam logic [7:0] OFS_OVF = 8'h08;       // Overflow flags.
  localparam logic [7:0] OFS_OVF_CLEAR = 8'h0C; // Overflow clear, write one.
  localparam logic [7:0] OFS_SELECT = 8'h10;    // Continue-mode bits.
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;  // Sticky events, W1C.
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;  // Interrupt mask.

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Per-line event word carried from the sequencer.
  typedef struct packed {
    logic [AIF_LINES-1:0] event_hit;
  } aif_evt_s;

  // APB request as seen by the slave.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aif_apb_req_s;

endpackage

/* rtl/aif_line.sv */
// One interrupt line: flag, overflow flag and pulse issue logic.
// Assumes events and clears are single-cycle pulses in the pclk domain.
`timescale 1ns/10ps
module aif_line
  import aif_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Controls.
  input wire logic event_in,
  input wire logic flag_clear,
  input wire logic ovf_clear,
  input wire logic continuous_irq_enable,
  // State and output.
  output logic conversion_irq_flag,
  output logic irq_overflow_flag,
  output logic irq_pulse
);

  // An event is issued unless the flag blocks it in single-shot mode.
  logic issue;
  assign issue = event_in && (continuous_irq_enable ||
                              !conversion_irq_flag);

  // Flag: set wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_irq_flag <= 1'b0;
    end else if (event_in) begin
      conversion_irq_flag <= 1'b1;
    end else if (flag_clear) begin
      conversion_irq_flag <= 1'b0;
    end
  end

  // Overflow records an event that met an already set flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_overflow_flag <= 1'b0;
    end else if (event_in && conversion_irq_flag) begin
      irq_overflow_flag <= 1'b1;
    end else if (ovf_clear) begin
      irq_overflow_flag <= 1'b0;
    end
  end

  // One-cycle interrupt pulse per issued event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= issue;
    end
  end

endmodule // aif_line

/* rtl/aif_top.sv */
// Converter interrupt flag block with APB register access.
// Assumes the sequencer drives one-cycle event pulses synchronous to pclk.
`timescale 1ns/10ps
module aif_top
  import aif_pkg::*;
#(
  parameter int LINES = AIF_LINES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer events.
  input wire logic [LINES-1:0] conv_event,
  // Interrupt outputs.
  output logic [LINES-1:0] conversion_irq_line,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // Line count must fit the packed event word that carries the events.
  // The event word is sized by the package, so more lines than it holds
  // would index past its top bit.
  if (LINES < 1 || LINES > AIF_LINES) begin : g_bad_lines
    $error("LINES must be between 1 and the package line count.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Decide whether an address is a mapped register.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_FLAG) || (a == OFS_CLEAR) || (a == OFS_OVF) ||
                (a == OFS_OVF_CLEAR) || (a == OFS_SELECT) ||
                (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  aif_apb_req_s req; // Bundled request.
  logic access; // Access phase, answered this cycle.
  logic wr; // Write taking effect this edge.
  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};
  assign access = req.psel && req.penable;
  assign wr = access && req.pwrite && is_mapped(req.paddr);

  // Write strobes to the one-shot clear registers.
  logic [LINES-1:0] flag_clear; // Write-one clear of flags.
  logic [LINES-1:0] ovf_clear; // Write-one clear of overflow flags.
  assign flag_clear = (wr && req.paddr == OFS_CLEAR) ?
                      req.pwdata[LINES-1:0] : '0;
  assign ovf_clear = (wr && req.paddr == OFS_OVF_CLEAR) ?
                     req.pwdata[LINES-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic [LINES-1:0] continuous_irq_enable; // Continue-mode bits.
  logic [LINES-1:0] irq_mask; // Interrupt mask.

  // Continue-mode register, steers each line's blocking behaviour.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      continuous_irq_enable <= RST_ZERO[LINES-1:0];
    end else if (wr && req.paddr == OFS_SELECT) begin
      continuous_irq_enable <= req.pwdata[LINES-1:0];
    end
  end

  // Mask register, same layout as the sticky status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= RST_ZERO[LINES-1:0];
    end else if (wr && req.paddr == OFS_IRQ_MASK) begin
      irq_mask <= req.pwdata[LINES-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt lines.

  aif_evt_s evt; // Event word from the sequencer.
  logic [LINES-1:0] conversion_irq_flag; // Per-line flags.
  logic [LINES-1:0] irq_overflow_flag; // Per-line overflow flags.
  logic [LINES-1:0] irq_pulse; // Issued interrupt pulses.
  assign evt.event_hit = AIF_LINES'(conv_event);

  // One flag unit per line.
  for (genvar i = 0; i < LINES; i++) begin : g_line
    aif_line u_line (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(evt.event_hit[i]),
      .flag_clear(flag_clear[i]),
      .ovf_clear(ovf_clear[i]),
      .continuous_irq_enable(continuous_irq_enable[i]),
      .conversion_irq_flag(conversion_irq_flag[i]),
      .irq_overflow_flag(irq_overflow_flag[i]),
      .irq_pulse(irq_pulse[i])
    );
  end

  // Issued pulses go straight out of the line flip-flops.
  assign conversion_irq_line = irq_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and combined interrupt.

  logic [LINES-1:0] irq_status; // Sticky issued-interrupt events.

  // Status bits set on each issued pulse; set wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_ZERO[LINES-1:0];
    end else begin
      irq_status <= irq_pulse |
        (irq_status & ~((wr && req.paddr == OFS_IRQ_STAT) ?
                        req.pwdata[LINES-1:0] : '0));
    end
  end

  // Level interrupt, registered, high while an unmasked bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [31:0] next_prdata; // Read data for the current address.

  // Read mux; clear registers read as zero.
  always_comb begin
    next_prdata = RST_ZERO;
    case (req.paddr)
      OFS_FLAG: next_prdata[LINES-1:0] = conversion_irq_flag;
      OFS_CLEAR: next_prdata = RST_ZERO;
      OFS_OVF: next_prdata[LINES-1:0] = irq_overflow_flag;
      OFS_SELECT: next_prdata[LINES-1:0] = continuous_irq_enable;
      OFS_IRQ_STAT: next_prdata[LINES-1:0] = irq_status;
      OFS_IRQ_MASK: next_prdata[LINES-1:0] = irq_mask;
      default: next_prdata = RST_ZERO;
    endcase
  end

  // Answer in the setup cycle's next edge: pready high in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_ZERO;
    end else if (req.psel && !req.penable) begin
      pready <= 1'b1;
      pslverr <= !is_mapped(req.paddr);
      prdata <= req.pwrite ? RST_ZERO : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_ZERO;
    end
  end

endmodule // aif_top

/* test/aif_monitor.sv */
// Port checker for aif_top with mirrored flag and continue bits.
// Assumes the bind below attaches it to every aif_top.
`timescale 1ns/10ps
module aif_monitor #(parameter int LINES = 4) (
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, irq,
  input wire logic [LINES-1:0] conv_event, conversion_irq_line
);
  logic [LINES-1:0] f, c; // Mirrored flags and continue bits.
  logic acc; // A write completing at this edge.
  assign acc = psel && penable && pready && pwrite;
  // A clear loses against an event in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f <= '0;
      c <= '0;
    end else begin
      if (acc && paddr == 8'h10) c <= pwdata[LINES-1:0];
      f <= (acc && paddr == 8'h04 ? f & ~pwdata[LINES-1:0] : f) | conv_event;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_one: assert property (psel && !penable |=> pready)
    else $error("pready missing");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_clear_zero: assert property (
    pready && !pwrite && paddr == 8'h04 |-> prdata == 0)
    else $error("clear register not zero");
  chk_pulse_model: assert property (
    conversion_irq_line == $past(conv_event & (c | ~f)))
    else $error("pulse mismatch");
  chk_block_hold: assert property (
    |(conv_event & f & ~c) |=> (conversion_irq_line & $past(f & ~c)) == 0)
    else $error("blocked line pulsed");
  chk_unmapped_err: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("no slave error");
  cover property (acc && paddr == 8'h04 && |(conv_event & pwdata));
  cover property (|(conv_event & f & ~c));
  cover property (|(conv_event & f & c));
endmodule // aif_monitor

bind aif_top aif_monitor #(.LINES(LINES)) i_aif_monitor (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .irq, .conv_event, .conversion_irq_line);

/* test/aif_cpu_model.sv */
// Interrupt-taking side: counts every issued line pulse.
// Assumes pulses last one pclk cycle.
`timescale 1ns/10ps
module aif_cpu_model #(parameter int LINES = 4) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LINES-1:0] conversion_irq_line,
  output int taken
);
  // Each set bit is one entry into the service routine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) taken <= 0;
    else taken <= taken + $countones(conversion_irq_line);
  end
endmodule // aif_cpu_model

/* test/tb_aif_top.sv */
// Self-checking bench for aif_top.
// Assumes aif_monitor is bound by its own file.
`timescale 1ns/10ps
module tb_aif_top;
  import aif_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h0000_005A;
  logic pready, pslverr, irq, err;
  logic [3:0] conv_event = 0, conversion_irq_line, b, r, s;
  int taken, fail_count = 0, checks = 0, t0;
  aif_top #(.LINES(4)) i_aif_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_event,
    .conversion_irq_line, .irq);
  aif_cpu_model #(.LINES(4)) i_aif_cpu_model (.pclk, .presetn,
    .conversion_irq_line, .taken);
  always #50 pclk = ~pclk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Two events on cleared flags: event lines once, continue event lines twice.
  function automatic int exp_pulses(logic [3:0] e, logic [3:0] k);
    return $countones(e) + $countones(e & k);
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // One APB transfer; e is an event pulse placed in the access cycle.
  task apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] e);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    conv_event <= e;
    n = 0;
    do begin
      @(posedge pclk);
      conv_event <= 0;
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("Error pready expected 1 seen %b", pready);
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdc(string n, logic [7:0] a, logic [31:0] e);
    apb(0, a, 0, 0);
    chk(n, e, rd);
  endtask
  task ev(logic [3:0] m);
    conv_event <= m;
    @(posedge pclk);
    conv_event <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    b = 4'b0001 << (rnd() % 4);
    rdc("flags", OFS_FLAG, 0);
    apb(1, OFS_IRQ_MASK, b, 0);
    ev(b);
    chk("pulses", 1, taken);
    chk("irq", 1, irq);
    ev(b);
    chk("pulses", 1, taken);
    rdc("ovf", OFS_OVF, b);
    apb(1, OFS_CLEAR, 0, 0);
    rdc("flags", OFS_FLAG, b);
    rdc("clear", OFS_CLEAR, 0);
    apb(1, OFS_CLEAR, b, b);
    rdc("flags", OFS_FLAG, b);
    rdc("ovf", OFS_OVF, b);
    apb(1, OFS_CLEAR, b, 0);
    rdc("flags", OFS_FLAG, 0);
    apb(1, OFS_IRQ_STAT, b, 0);
    apb(1, OFS_IRQ_MASK, 0, 0);
    repeat (2) @(posedge pclk);
    chk("irq", 0, irq);
    for (int k = 0; k < 6; k++) begin
      r = 4'(rnd());
      s = 4'(rnd());
      apb(1, OFS_SELECT, {28'h000_0000, s}, 0);
      apb(1, OFS_CLEAR, 32'h0000_000F, 0);
      t0 = taken;
      ev(r);
      ev(r);
      chk("pulses", t0 + exp_pulses(r, s), taken);
    end
    chk("irq", 0, irq);
    apb(1, OFS_OVF_CLEAR, 32'h0000_000F, 0);
    rdc("ovf", OFS_OVF, 0);
    apb(0, 8'h40, 0, 0);
    chk("pslverr", 1, err);
    chk("rdata", 0, rd);
    tally_and_finish();
  end
endmodule // tb_aif_top
